// File: hdl/line_ctrl_pkg.sv
package line_ctrl_pkg;
	// Register offsets on the control port
	localparam logic [7:0] LINE_CONTROL_FIVE_OFS = 8'h1F;
	localparam logic [7:0] GROUND_START_OFS = 8'h20;
	// Reset values
	localparam logic [7:0] LINE_CONTROL_FIVE_RST = 8'h20;
	localparam logic [7:0] GROUND_START_RST = 8'h07;
	// Field positions, line-control register
	localparam int FULL_SCALE_BIT = 7;
	localparam int FAST_OFFHOOK_HI = 6;
	localparam int FAST_OFFHOOK_LO = 5;
	localparam int RSVD_HI_BIT = 4;
	localparam int ONHOOK_SPEED_HI_BIT = 3;
	localparam int RSVD_LO_BIT = 2;
	localparam int RX_HPF_BIT = 1;
	localparam int LINE_VOLT_FORCE_OFF_BIT = 0;
	// Field positions, ground-start register
	localparam int TIP_GROUND_SEEN_BIT = 2;
	localparam int TIP_DETECT_RELAY_BIT = 1;
	localparam int RING_GROUND_RELAY_BIT = 0;
	// Readable bits of the line-control register
	localparam logic [7:0] LINE_CONTROL_FIVE_MASK = 8'hEB;
	// Timing
	localparam int CLK_HZ = 125000000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int MS_W = 10;
	// Off-hook counter lengths in ms
	localparam logic [9:0] OFFHOOK_MS_00 = 10'h200;
	localparam logic [9:0] OFFHOOK_MS_01 = 10'h080;
	localparam logic [9:0] OFFHOOK_MS_10 = 10'h040;
	localparam logic [9:0] OFFHOOK_MS_11 = 10'h008;
	// On-hook release lengths in ms (fast one is immediate)
	localparam logic [9:0] ONHOOK_MS_FAST = 10'h000;
	localparam logic [9:0] ONHOOK_MS_ETSI = 10'h003;
	localparam logic [9:0] ONHOOK_MS_QUENCH = 10'h01A;
	localparam logic [1:0] SQUELCH_QUENCH = 2'h3;
	// Line voltage forced to zero at or below this magnitude in volts
	localparam logic [7:0] LINE_VOLT_FORCE_MAX = 8'h03;
endpackage : line_ctrl_pkg

// File: hdl/ms_countdown.sv
`timescale 1ns/1ps
// Millisecond down-counter, loaded by a pulse, stepped by a 1 ms enable
module ms_countdown (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Control
	input wire logic load_i,
	input wire logic [9:0] load_ms_i,
	input wire logic ms_tick_i,
	// Status
	output logic busy_o
);
	logic [9:0] count;

	// Load wins over a tick in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			count <= 10'h000;
		end else if (load_i) begin
			count <= load_ms_i;
		end else if (ms_tick_i && count != 10'h000) begin
			count <= count - 10'h001;
		end
	end

	assign busy_o = (count != 10'h000);
endmodule : ms_countdown

// File: hdl/daa_line_ctrl_ground_start_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Line-control register resets to 0x20, off-hook field at its default code.
// - Full-scale bit drives the converter full-scale level output.
// - Off-hook field bits 6:5 set counter length; 00 gives 512 ms.
// - On-hook speed from both speed bits and squelch: fast, 3 ms, 26 ms.
// - Filter bit picks receive high-pass corner, 5 Hz clear, 200 Hz set.
// - Force-off clear forces line voltage status to zero at 3 V or less in magnitude, either polarity.
// - Ground-start register resets with both relay bits at one.
// - Tip-ground status reads zero while tip current flows with the tip relay closed (tip detect bit zero), else one.
// - Tip detect bit zero closes the tip relay, one opens it.
// - Ring-ground bit zero closes the ring relay, one opens it.
module daa_line_ctrl_ground_start_regs #(
	parameter int MS_CYCLES = line_ctrl_pkg::MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Bits held in other registers
	input wire logic onhook_speed_lo_i,
	input wire logic [1:0] squelch_sel_i,
	input wire logic hook_request_i,
	// Line sensing
	input wire logic [7:0] line_volt_raw_i,
	input wire logic tip_current_i,
	// Analog controls
	output logic full_scale_o,
	output logic rx_hpf_corner_sel_o,
	output logic line_volt_force_off_o,
	output logic [7:0] line_volt_status_o,
	// Hook timing
	output logic offhook_valid_o,
	output logic loop_hold_o,
	// Relay drives, one means open
	output logic tip_detect_relay_ctl_o,
	output logic ring_ground_relay_ctl_o
);
	logic [7:0] line_control_five;
	logic tip_detect_relay_ctl;
	logic ring_ground_relay_ctl;
	logic tip_ground_seen;
	logic tip_meta;
	logic tip_sync;
	logic hook_q;
	logic [16:0] ms_div;
	logic ms_tick;
	logic offhook_busy;
	logic onhook_busy;
	logic hook_rise;
	logic hook_fall;
	logic [9:0] next_onhook_ms;
	logic [7:0] next_rdata;
	logic volt_small;

	// Off-hook length from the two-bit field
	function automatic logic [9:0] offhook_ms(input logic [1:0] sel);
		unique case (sel)
			2'h0: offhook_ms = line_ctrl_pkg::OFFHOOK_MS_00;
			2'h1: offhook_ms = line_ctrl_pkg::OFFHOOK_MS_01;
			2'h2: offhook_ms = line_ctrl_pkg::OFFHOOK_MS_10;
			2'h3: offhook_ms = line_ctrl_pkg::OFFHOOK_MS_11;
		endcase
	endfunction : offhook_ms

	// Line-control writes; reserved bits are kept at zero
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			line_control_five <= line_ctrl_pkg::LINE_CONTROL_FIVE_RST;
		end else if (reg_wr_i &&
			reg_addr_i == line_ctrl_pkg::LINE_CONTROL_FIVE_OFS) begin
			line_control_five <= reg_wdata_i &
				line_ctrl_pkg::LINE_CONTROL_FIVE_MASK;
		end
	end

	// Relay bits; reset leaves both relays open
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tip_detect_relay_ctl <= 1'b1;
			ring_ground_relay_ctl <= 1'b1;
		end else if (reg_wr_i &&
			reg_addr_i == line_ctrl_pkg::GROUND_START_OFS) begin
			tip_detect_relay_ctl <=
				reg_wdata_i[line_ctrl_pkg::TIP_DETECT_RELAY_BIT];
			ring_ground_relay_ctl <=
				reg_wdata_i[line_ctrl_pkg::RING_GROUND_RELAY_BIT];
		end
	end

	// Tip current pin is asynchronous to clk_i
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tip_meta <= 1'b0;
			tip_sync <= 1'b0;
		end else begin
			tip_meta <= tip_current_i;
			tip_sync <= tip_meta;
		end
	end

	// Current can only flow with the tip relay closed
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tip_ground_seen <= 1'b1;
		end else begin
			tip_ground_seen <= ~(tip_sync & ~tip_detect_relay_ctl);
		end
	end

	// Analog control and relay outputs
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			full_scale_o <= 1'b0;
			rx_hpf_corner_sel_o <= 1'b0;
			line_volt_force_off_o <= 1'b0;
			tip_detect_relay_ctl_o <= 1'b1;
			ring_ground_relay_ctl_o <= 1'b1;
		end else begin
			full_scale_o <= line_control_five[line_ctrl_pkg::FULL_SCALE_BIT];
			rx_hpf_corner_sel_o <=
				line_control_five[line_ctrl_pkg::RX_HPF_BIT];
			line_volt_force_off_o <=
				line_control_five[line_ctrl_pkg::LINE_VOLT_FORCE_OFF_BIT];
			tip_detect_relay_ctl_o <= tip_detect_relay_ctl;
			ring_ground_relay_ctl_o <= ring_ground_relay_ctl;
		end
	end

	// Small voltages of either polarity, two's complement
	assign volt_small = ($signed(line_volt_raw_i) <=
		$signed(line_ctrl_pkg::LINE_VOLT_FORCE_MAX)) &&
		($signed(line_volt_raw_i) >=
		-$signed(line_ctrl_pkg::LINE_VOLT_FORCE_MAX));

	// Status reading; forcing hides noise near zero volts
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			line_volt_status_o <= 8'h00;
		end else if (volt_small &&
			!line_control_five[line_ctrl_pkg::LINE_VOLT_FORCE_OFF_BIT]) begin
			line_volt_status_o <= 8'h00;
		end else begin
			line_volt_status_o <= line_volt_raw_i;
		end
	end

	// 1 ms enable; timers therefore carry up to 1 ms of phase error
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ms_div <= 17'h00000;
			ms_tick <= 1'b0;
		end else if (ms_div == 17'(MS_CYCLES - 1)) begin
			ms_div <= 17'h00000;
			ms_tick <= 1'b1;
		end else begin
			ms_div <= ms_div + 17'h00001;
			ms_tick <= 1'b0;
		end
	end

	// Hook edges
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			hook_q <= 1'b0;
		end else begin
			hook_q <= hook_request_i;
		end
	end
	assign hook_rise = hook_request_i & ~hook_q;
	assign hook_fall = ~hook_request_i & hook_q;

	// On-hook release time from the speed bits and squelch
	always_comb begin
		next_onhook_ms = line_ctrl_pkg::ONHOOK_MS_FAST;
		if (onhook_speed_lo_i &&
			squelch_sel_i == line_ctrl_pkg::SQUELCH_QUENCH) begin
			next_onhook_ms = line_ctrl_pkg::ONHOOK_MS_QUENCH;
		end else if (!onhook_speed_lo_i &&
			line_control_five[line_ctrl_pkg::ONHOOK_SPEED_HI_BIT] &&
			squelch_sel_i == 2'h0) begin
			next_onhook_ms = line_ctrl_pkg::ONHOOK_MS_ETSI;
		end
	end

	// Off-hook qualification counter
	ms_countdown u_offhook (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.load_i(hook_rise),
		.load_ms_i(offhook_ms(line_control_five[
			line_ctrl_pkg::FAST_OFFHOOK_HI:line_ctrl_pkg::FAST_OFFHOOK_LO])),
		.ms_tick_i(ms_tick),
		.busy_o(offhook_busy)
	);

	// On-hook release counter
	ms_countdown u_onhook (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.load_i(hook_fall),
		.load_ms_i(next_onhook_ms),
		.ms_tick_i(ms_tick),
		.busy_o(onhook_busy)
	);

	// Hook timing outputs
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			offhook_valid_o <= 1'b0;
			loop_hold_o <= 1'b0;
		end else begin
			offhook_valid_o <= hook_q & hook_request_i & ~offhook_busy;
			loop_hold_o <= hook_request_i | hook_fall | onhook_busy;
		end
	end
	// Read data; unmapped offsets read zero
	always_comb begin
		next_rdata = 8'h00;
		if (reg_addr_i == line_ctrl_pkg::LINE_CONTROL_FIVE_OFS) begin
			next_rdata = line_control_five;
		end else if (reg_addr_i == line_ctrl_pkg::GROUND_START_OFS) begin
			next_rdata = {5'h00, tip_ground_seen, tip_detect_relay_ctl,
				ring_ground_relay_ctl};
		end
	end
	// Read data stands until the next read
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

	sequence s_wr_gs;
		reg_wr_i && reg_addr_i == line_ctrl_pkg::GROUND_START_OFS;
	endsequence
	property p_rst_lc;
		@(posedge clk_i) !rstn_i |=> line_control_five == 8'h20;
	endproperty
	a_rst_lc: assert property (p_rst_lc) else $error("line ctrl reset");
	property p_rst_relay;
		@(posedge clk_i) !rstn_i |=> ##1 tip_detect_relay_ctl_o &&
			ring_ground_relay_ctl_o;
	endproperty
	a_rst_relay: assert property (p_rst_relay) else $error("relay reset");
	property p_full;
		@(posedge clk_i) disable iff (!rstn_i)
		reg_wr_i && reg_addr_i == 8'h1F |=> ##1
			full_scale_o == $past(reg_wdata_i[7], 2);
	endproperty
	a_full: assert property (p_full) else $error("full scale");
	property p_hpf;
		@(posedge clk_i) disable iff (!rstn_i)
		reg_wr_i && reg_addr_i == 8'h1F |=> ##1
			rx_hpf_corner_sel_o == $past(reg_wdata_i[1], 2);
	endproperty
	a_hpf: assert property (p_hpf) else $error("hpf corner");
	property p_ring;
		@(posedge clk_i) disable iff (!rstn_i)
		s_wr_gs |=> ##1 ring_ground_relay_ctl_o == $past(reg_wdata_i[0], 2);
	endproperty
	a_ring: assert property (p_ring) else $error("ring relay");
	property p_tip_open;
		@(posedge clk_i) disable iff (!rstn_i)
		tip_detect_relay_ctl ##1 tip_detect_relay_ctl |-> tip_ground_seen;
	endproperty
	a_tip_open: assert property (p_tip_open) else $error("tip open");
	property p_tgd;
		@(posedge clk_i) disable iff (!rstn_i)
		!tip_detect_relay_ctl && tip_sync |=> !tip_ground_seen;
	endproperty
	a_tgd: assert property (p_tgd) else $error("tip ground");
	property p_force;
		@(posedge clk_i) disable iff (!rstn_i)
		volt_small && !line_control_five[0] |=> line_volt_status_o == 8'h00;
	endproperty
	a_force: assert property (p_force) else $error("volt force");
	property p_rsvd;
		@(posedge clk_i) disable iff (!rstn_i)
		!line_control_five[4] && !line_control_five[2];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits");
	property p_offhook_early;
		@(posedge clk_i) disable iff (!rstn_i)
		hook_rise |=> !offhook_valid_o [*3];
	endproperty
	a_offhook_early: assert property (p_offhook_early)
		else $error("offhook early");
endmodule : daa_line_ctrl_ground_start_regs

// File: sim/co_line_model.sv
`timescale 1ns/1ps
// Far side: exchange and relays on tip and ring
module co_line_model (
	// Relay drives from the block, one means open
	input wire logic tip_detect_relay_ctl_i,
	input wire logic ring_ground_relay_ctl_i,
	// Scenario controls
	input wire logic co_ground_tip_i,
	input wire logic [7:0] co_volt_i,
	// Sensing back into the block
	output logic tip_current_o,
	output logic [7:0] line_volt_raw_o
);
	// Current only through a closed tip relay, so open relay hides grounding
	assign tip_current_o = co_ground_tip_i & ~tip_detect_relay_ctl_i;
	// Ring relay sinks current only; loop voltage passes unchanged
	assign line_volt_raw_o = co_volt_i ^ {8{1'b0 & ring_ground_relay_ctl_i}};
endmodule : co_line_model

// File: sim/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the line and ground-start registers
module tb;
	localparam int MSC = 20;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic onhook_speed_lo_i = 1'b0;
	logic [1:0] squelch_sel_i = 2'h0;
	logic hook_request_i = 1'b0;
	logic co_ground = 1'b0;
	logic [7:0] co_volt = 8'h00;
	logic [7:0] reg_rdata_o, line_volt_status_o, line_volt_raw_i;
	logic full_scale_o, rx_hpf_corner_sel_o, line_volt_force_off_o;
	logic offhook_valid_o, loop_hold_o, tip_current_i;
	logic tip_detect_relay_ctl_o, ring_ground_relay_ctl_o;
	int seed = 42591;
	int n_mismatch = 0;
	int checks_done = 0;
	int ohms[4] = '{512, 128, 64, 8};
	int rel[4] = '{0, 3, 26, 26};
	int c, v, t;
	logic [7:0] lc;
	logic [7:0] d;

	// Free-running clock
	always #4 clk_i = ~clk_i;

	daa_line_ctrl_ground_start_regs #(
		.MS_CYCLES(MSC)
	) i_daa_line_ctrl_ground_start_regs (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.onhook_speed_lo_i(onhook_speed_lo_i),
		.squelch_sel_i(squelch_sel_i),
		.hook_request_i(hook_request_i),
		.line_volt_raw_i(line_volt_raw_i),
		.tip_current_i(tip_current_i),
		.full_scale_o(full_scale_o),
		.rx_hpf_corner_sel_o(rx_hpf_corner_sel_o),
		.line_volt_force_off_o(line_volt_force_off_o),
		.line_volt_status_o(line_volt_status_o),
		.offhook_valid_o(offhook_valid_o),
		.loop_hold_o(loop_hold_o),
		.tip_detect_relay_ctl_o(tip_detect_relay_ctl_o),
		.ring_ground_relay_ctl_o(ring_ground_relay_ctl_o)
	);

	co_line_model i_co_line_model (
		.tip_detect_relay_ctl_i(tip_detect_relay_ctl_o),
		.ring_ground_relay_ctl_i(ring_ground_relay_ctl_o),
		.co_ground_tip_i(co_ground),
		.co_volt_i(co_volt),
		.tip_current_o(tip_current_i),
		.line_volt_raw_o(line_volt_raw_i)
	);

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= dat;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk({8'h00, reg_rdata_o}, {8'h00, exp});
	endtask : rd

	task stop_test;
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	// Cut a hang short well past the expected run length
	initial begin
		#(8 * 40000);
		n_mismatch++;
		stop_test();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(negedge clk_i);
		chk({tip_detect_relay_ctl_o, ring_ground_relay_ctl_o}, 16'h3);
		rd(line_ctrl_pkg::LINE_CONTROL_FIVE_OFS, 8'h20);
		rd(line_ctrl_pkg::GROUND_START_OFS, 8'h07);
		rd(8'h21, 8'h00);
		$display("Reset test done");
		// Random fields, reserved bits clear, voltage near the forcing band
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			d[0] = i[0];
			d[line_ctrl_pkg::RSVD_HI_BIT] = 1'b0;
			d[line_ctrl_pkg::RSVD_LO_BIT] = 1'b0;
			// Last passes act as software for the lowest-tier line side
			if (i >= 6) begin
				d[line_ctrl_pkg::FULL_SCALE_BIT] = 1'b0;
			end
			lc = d & line_ctrl_pkg::LINE_CONTROL_FIVE_MASK;
			wr(line_ctrl_pkg::LINE_CONTROL_FIVE_OFS, d);
			rd(line_ctrl_pkg::LINE_CONTROL_FIVE_OFS, lc);
			chk({full_scale_o, rx_hpf_corner_sel_o}, {lc[7], lc[1]});
			v = $random(seed) % 6;
			co_volt <= 8'(v);
			repeat (3) @(posedge clk_i);
			#1;
			t = (!lc[0] && v >= -3 && v <= 3) ? 0 : v;
			chk({line_volt_force_off_o, line_volt_status_o}, {lc[0], 8'(t)});
		end
		$display("Line control test done");
		wr(line_ctrl_pkg::GROUND_START_OFS, 8'hFC);
		chk({tip_detect_relay_ctl_o, ring_ground_relay_ctl_o}, 16'h0);
		rd(line_ctrl_pkg::GROUND_START_OFS, 8'h04);
		co_ground <= 1'b1;
		repeat (5) @(posedge clk_i);
		rd(line_ctrl_pkg::GROUND_START_OFS, 8'h00);
		co_ground <= 1'b0;
		repeat (5) @(posedge clk_i);
		rd(line_ctrl_pkg::GROUND_START_OFS, 8'h04);
		co_ground <= 1'b1;
		wr(line_ctrl_pkg::GROUND_START_OFS, 8'h02);
		repeat (5) @(posedge clk_i);
		rd(line_ctrl_pkg::GROUND_START_OFS, 8'h06);
		co_ground <= 1'b0;
		$display("Ground start test done");
		// Every off-hook code, timed from hook rise
		for (int k = 0; k < 4; k++) begin
			wr(line_ctrl_pkg::LINE_CONTROL_FIVE_OFS, {1'b0, 2'(k), 5'h00});
			hook_request_i <= 1'b1;
			c = 0;
			while (offhook_valid_o !== 1'b1 && c < 12000) begin
				@(posedge clk_i);
				c++;
			end
			t = ohms[k];
			chk(16'(c >= (t - 1) * MSC && c <= t * MSC + 3), 16'h1);
			hook_request_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			chk({15'h0, offhook_valid_o}, 16'h0);
		end
		$display("Off-hook test done");
		// Release speed for each listed bit combination
		for (int k = 0; k < 4; k++) begin
			wr(line_ctrl_pkg::LINE_CONTROL_FIVE_OFS, {4'h2, k[0], 3'h0});
			onhook_speed_lo_i <= k[1];
			squelch_sel_i <= {2{k[1]}};
			hook_request_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			hook_request_i <= 1'b0;
			c = 0;
			@(posedge clk_i);
			while (loop_hold_o !== 1'b0 && c < 1000) begin
				@(posedge clk_i);
				c++;
			end
			t = rel[k];
			// Fast release must not linger; timed ones must not end early
			if (t == 0) begin
				v = int'(c <= 3);
			end else begin
				v = int'(c >= (t - 1) * MSC && c <= t * MSC + 4);
			end
			chk(16'(v), 16'h1);
		end
		$display("On-hook test done");
		stop_test();
	end
endmodule : tb
